// ==== design/uxr_top.sv ====
/*
 Register access logic for the standard, 650 style, extended and indexed
 register sets of a single-channel UART. Assumes a host bus and status
 sources on i_clk; the modem pins DTR and RTS arrive asynchronously.
*/
`timescale 1ns/100ps
module uxr_top #(
   parameter logic [7:0] IDENT_1 = 8'h5a // Arbitrary identity value.
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_soft_rst,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire uxr_pkg::uxr_status_t i_status,
   input wire logic i_dtr_pin,
   input wire logic i_rts_pin,
   input wire logic i_nine_bit,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output uxr_pkg::uxr_cfg_t o_cfg,
   output logic o_special_mode
);
   logic rst;
   logic wr;
   logic rd;
   logic key_mode;
   logic dlab;
   logic stat_en;
   logic win_rd;
   logic wr_win;
   logic [1:0] pins;
   logic [7:0] line_control;
   logic [7:0] interrupt_enable;
   logic [7:0] modem_control;
   logic [7:0] scratch_offset;
   logic [7:0] div_lo;
   logic [7:0] div_hi;
   logic [7:0] enhanced_features;
   logic [7:0] resume_char_1;
   logic [7:0] resume_char_2;
   logic [7:0] pause_char_1;
   logic [7:0] pause_char_2;
   logic [7:0] additional_control;
   logic [7:0] clock_prescaler;
   logic [7:0] sample_clock_select;
   logic [7:0] clock_source_select;
   logic [6:0] tx_irq_trigger;
   logic [6:0] rx_irq_trigger;
   logic [6:0] flow_low_threshold;
   logic [6:0] flow_high_threshold;
   logic [1:0] tx_disable_ctl;
   logic [7:0] stat_rd;
   logic [7:0] win_data;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Access qualifiers.
   assign rst = i_srst || (i_ce && i_soft_rst);
   assign wr = i_ce && i_wr;
   assign rd = i_ce && i_rd;
   assign key_mode = (line_control == uxr_pkg::KEY_650);
   assign dlab = line_control[uxr_pkg::B_DLAB];
   assign stat_en = additional_control[uxr_pkg::B_STAT_EN];
   assign win_rd = additional_control[uxr_pkg::B_WIN_RD];
   // window writes blocked in key mode.
   assign wr_win = wr && i_addr == uxr_pkg::A_WIN && !key_mode;

   // DTR and RTS pin levels cross into the clock domain first.
   uxr_sync #(.W(2)) u_pins (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
      .i_d({i_dtr_pin, i_rts_pin}), .o_q(pins));

   ////////////////////////////////////////////////////////////////////////
   // Standard registers; reset values come from each instance.
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_line (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(line_control), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_LINE));
   // interrupt enable only while status enable is clear.
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_ien (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(interrupt_enable), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_IEN && !dlab && !stat_en));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_modem (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(modem_control), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_MODEM && !key_mode));
   // the offset is written at address 111.
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_scr (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(scratch_offset), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_SCR && !key_mode));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_DIV_LO)) u_div_lo (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(div_lo), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_DATA && dlab));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_div_hi (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(div_hi), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_IEN && dlab));
   // only the two disable bits take host data.
   uxr_reg #(.W(2), .RST(uxr_pkg::RST_STAT_CTL)) u_txdis (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(tx_disable_ctl), .i_d(i_wdata[1:0]),
      .i_we(wr && i_addr == uxr_pkg::A_IEN && !dlab && stat_en));

   ////////////////////////////////////////////////////////////////////////
   // 650 style registers, reachable only in key mode.
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_feat (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(enhanced_features), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_FEAT && key_mode));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_res1 (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(resume_char_1), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_MODEM && key_mode));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_res2 (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(resume_char_2), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_WIN && key_mode));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_pau1 (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(pause_char_1), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_MSTAT && key_mode));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_pau2 (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(pause_char_2), .i_d(i_wdata),
      .i_we(wr && i_addr == uxr_pkg::A_SCR && key_mode));

   ////////////////////////////////////////////////////////////////////////
   // window writes land on the register the offset selects.
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_actl (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(additional_control), .i_d(i_wdata),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_ACTL));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_PRESC)) u_presc (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(clock_prescaler), .i_d(i_wdata),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_PRESC));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_sclk (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(sample_clock_select), .i_d(i_wdata),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_SCLK));
   uxr_reg #(.W(8), .RST(uxr_pkg::RST_ZERO)) u_csrc (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(clock_source_select), .i_d(i_wdata),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_CSRC));
   // levels keep seven bits; bit 7 is dropped on write.
   uxr_reg #(.W(7), .RST(uxr_pkg::RST_LEVEL)) u_txtrig (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(tx_irq_trigger), .i_d(i_wdata[6:0]),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_TXTRIG));
   uxr_reg #(.W(7), .RST(uxr_pkg::RST_LEVEL)) u_rxtrig (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(rx_irq_trigger), .i_d(i_wdata[6:0]),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_RXTRIG));
   uxr_reg #(.W(7), .RST(uxr_pkg::RST_LEVEL)) u_flowlo (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(flow_low_threshold), .i_d(i_wdata[6:0]),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_FLOWLO));
   uxr_reg #(.W(7), .RST(uxr_pkg::RST_LEVEL)) u_flowhi (.i_clk(i_clk),
      .i_srst(rst), .i_ce(i_ce), .o_q(flow_high_threshold),
      .i_d(i_wdata[6:0]),
      .i_we(wr_win && scratch_offset == uxr_pkg::X_FLOWHI));

   ////////////////////////////////////////////////////////////////////////
   // Additional status: live bits from the core and pins, two stored bits.
   assign stat_rd = {i_status.tx_idle, i_status.fifo_size, i_status.fifo_sel,
      i_status.special_det, pins, tx_disable_ctl};

   // indexed read selected by the scratch offset; unknown offsets read 0.
   always_comb
   begin
      case (scratch_offset)
         uxr_pkg::X_ACTL: win_data = additional_control;
         uxr_pkg::X_PRESC: win_data = clock_prescaler;
         uxr_pkg::X_SCLK: win_data = sample_clock_select;
         uxr_pkg::X_CSRC: win_data = clock_source_select;
         uxr_pkg::X_TXTRIG: win_data = {1'b0, tx_irq_trigger};
         uxr_pkg::X_RXTRIG: win_data = {1'b0, rx_irq_trigger};
         uxr_pkg::X_FLOWLO: win_data = {1'b0, flow_low_threshold};
         uxr_pkg::X_FLOWHI: win_data = {1'b0, flow_high_threshold};
         uxr_pkg::X_IDENT: win_data = IDENT_1;
         default: win_data = 8'h00;
      endcase
   end

   // Read mux; receive data lives in the core, so address 000 reads zero here unless divisor access is set.
   always_comb
   begin
      next_rdata = 8'h00;
      case (i_addr)
         uxr_pkg::A_DATA: next_rdata = dlab ? div_lo : 8'h00;
         // status view needs divisor access clear.
         uxr_pkg::A_IEN: next_rdata = dlab ? div_hi :
            (stat_en ? stat_rd : interrupt_enable);
         uxr_pkg::A_FEAT: next_rdata = key_mode ? enhanced_features :
            i_status.int_status;
         // level replaces line control while status enable is set.
         uxr_pkg::A_LINE: next_rdata = stat_en ? i_status.rx_level :
            line_control;
         // tx level hidden in key mode.
         uxr_pkg::A_MODEM: next_rdata = key_mode ? resume_char_1 :
            (stat_en ? i_status.tx_level : modem_control);
         // line status or window by the read enable.
         uxr_pkg::A_WIN: next_rdata = key_mode ? resume_char_2 :
            (win_rd ? win_data : i_status.line_status);
         uxr_pkg::A_MSTAT: next_rdata = key_mode ? pause_char_1 :
            i_status.modem_status;
         uxr_pkg::A_SCR: next_rdata = key_mode ? pause_char_2 :
            scratch_offset;
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data is registered; it holds until the next read.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end
      else if (i_ce)
      begin
         o_rvalid <= i_rd;
         if (i_rd)
            o_rdata <= next_rdata;
      end
   end

   // nine-bit mode turns the flow characters into match characters.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_special_mode <= 1'b0;
      else if (i_ce)
         o_special_mode <= i_nine_bit;
   end

   // Every field below is a register output.
   assign o_cfg = '{line_control: line_control,
      interrupt_enable: interrupt_enable, modem_control: modem_control,
      divisor: {div_hi, div_lo}, enhanced_features: enhanced_features,
      resume_char_1: resume_char_1, resume_char_2: resume_char_2,
      pause_char_1: pause_char_1, pause_char_2: pause_char_2,
      additional_control: additional_control,
      clock_prescaler: clock_prescaler,
      sample_clock_select: sample_clock_select,
      clock_source_select: clock_source_select,
      tx_irq_trigger: tx_irq_trigger, rx_irq_trigger: rx_irq_trigger,
      flow_low_threshold: flow_low_threshold,
      flow_high_threshold: flow_high_threshold,
      tx_disable_ctl: tx_disable_ctl};

   ////////////////////////////////////////////////////////////////////////
   // Checks on the gating; soft reset is folded into the disable.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (rst);

   stat_view_a: assert property (rd && i_addr == uxr_pkg::A_IEN && !dlab
      && stat_en |=> o_rdata == $past(stat_rd))
      else $error("status view not returned");
   ien_map_a: assert property (wr && i_addr == uxr_pkg::A_IEN && !dlab
      && !stat_en |=> interrupt_enable == $past(i_wdata))
      else $error("interrupt enable write lost");
   level_view_a: assert property (rd && i_addr == uxr_pkg::A_LINE
      && stat_en |=> o_rdata == $past(i_status.rx_level) && o_rvalid)
      else $error("rx level not returned");
   line_read_a: assert property (rd && i_addr == uxr_pkg::A_LINE
      && !stat_en |=> o_rdata == $past(line_control))
      else $error("line control not returned");
   stat_mask_a: assert property (wr && i_addr == uxr_pkg::A_IEN && !dlab
      && stat_en |=> tx_disable_ctl == $past(i_wdata[1:0])
      && $stable(interrupt_enable))
      else $error("status write touched wrong bits");
   lsr_read_a: assert property (rd && i_addr == uxr_pkg::A_WIN && !key_mode
      && !win_rd |=> o_rdata == $past(i_status.line_status))
      else $error("line status not returned");
   win_read_a: assert property (rd && i_addr == uxr_pkg::A_WIN && !key_mode
      && win_rd |=> o_rdata == $past(win_data))
      else $error("window data not returned");
   key_guard_a: assert property (wr && i_addr == uxr_pkg::A_WIN && key_mode
      |=> $stable(additional_control) && resume_char_2 == $past(i_wdata))
      else $error("window written in key mode");
   win_write_a: assert property (wr_win
      && scratch_offset == uxr_pkg::X_RXTRIG
      |=> rx_irq_trigger == $past(i_wdata[6:0]))
      else $error("indexed write misrouted");
   level_width_a: assert property (rd && i_addr == uxr_pkg::A_WIN
      && !key_mode && win_rd && scratch_offset == uxr_pkg::X_RXTRIG
      |=> o_rdata[7] == 1'b0)
      else $error("trigger level read with bit 7 set");
   feat_guard_a: assert property (wr && i_addr == uxr_pkg::A_FEAT
      && !key_mode |=> $stable(enhanced_features))
      else $error("feature register written outside key mode");
   reset_val_a: assert property (disable iff (1'b0) i_srst
      |=> clock_prescaler == uxr_pkg::RST_PRESC
      && div_lo == uxr_pkg::RST_DIV_LO && additional_control == 8'h00)
      else $error("reset values wrong");
   nine_bit_a: assert property (i_ce |=> o_special_mode == $past(i_nine_bit))
      else $error("special mode not following nine-bit mode");

   key_entry_c: cover property (wr && i_addr == uxr_pkg::A_LINE
      && i_wdata == uxr_pkg::KEY_650);
   win_read_c: cover property (rd && i_addr == uxr_pkg::A_WIN && win_rd
      && !key_mode);
   stat_read_c: cover property (rd && i_addr == uxr_pkg::A_IEN && stat_en);
   win_write_c: cover property (wr_win
      && scratch_offset == uxr_pkg::X_RXTRIG);
endmodule

// ==== inc/uxr_pkg.sv ====
/*
 Constants and carrier types for the extended register access block of a
 single-channel UART. Assumes the host register port and the status sources
 run on the same clock as the block.
*/
package uxr_pkg;
   // Host addresses of the shared three-bit register space.
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_IEN = 3'h1;
   localparam logic [2:0] A_FEAT = 3'h2;
   localparam logic [2:0] A_LINE = 3'h3;
   localparam logic [2:0] A_MODEM = 3'h4;
   localparam logic [2:0] A_WIN = 3'h5;
   localparam logic [2:0] A_MSTAT = 3'h6;
   localparam logic [2:0] A_SCR = 3'h7;
   // Offsets of the indexed control set, as held in the scratch register.
   localparam logic [7:0] X_ACTL = 8'h00;
   localparam logic [7:0] X_PRESC = 8'h01;
   localparam logic [7:0] X_SCLK = 8'h02;
   localparam logic [7:0] X_CSRC = 8'h03;
   localparam logic [7:0] X_TXTRIG = 8'h04;
   localparam logic [7:0] X_RXTRIG = 8'h05;
   localparam logic [7:0] X_FLOWLO = 8'h06;
   localparam logic [7:0] X_FLOWHI = 8'h07;
   localparam logic [7:0] X_IDENT = 8'h08;
   // Key value and reset values.
   localparam logic [7:0] KEY_650 = 8'hbf;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DIV_LO = 8'h01;
   localparam logic [7:0] RST_PRESC = 8'h20;
   localparam logic [6:0] RST_LEVEL = 7'h00;
   localparam logic [1:0] RST_STAT_CTL = 2'h0;
   // Bit positions of the gating controls.
   localparam int B_DLAB = 7;
   localparam int B_STAT_EN = 7;
   localparam int B_WIN_RD = 6;

   // Status gathered from the UART core on the same clock.
   typedef struct packed {
      logic tx_idle;
      logic fifo_size;
      logic fifo_sel;
      logic special_det;
      logic [7:0] int_status;
      logic [7:0] line_status;
      logic [7:0] modem_status;
      logic [7:0] rx_level;
      logic [7:0] tx_level;
   } uxr_status_t;

   // Register contents handed to the UART core.
   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] interrupt_enable;
      logic [7:0] modem_control;
      logic [15:0] divisor;
      logic [7:0] enhanced_features;
      logic [7:0] resume_char_1;
      logic [7:0] resume_char_2;
      logic [7:0] pause_char_1;
      logic [7:0] pause_char_2;
      logic [7:0] additional_control;
      logic [7:0] clock_prescaler;
      logic [7:0] sample_clock_select;
      logic [7:0] clock_source_select;
      logic [6:0] tx_irq_trigger;
      logic [6:0] rx_irq_trigger;
      logic [6:0] flow_low_threshold;
      logic [6:0] flow_high_threshold;
      logic [1:0] tx_disable_ctl;
   } uxr_cfg_t;
endpackage

// ==== design/uxr_reg.sv ====
/*
 One writable register with a reset value and a write strobe.
 Assumes a synchronous reset and a clock enable on the same clock.
*/
`timescale 1ns/100ps
module uxr_reg #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic i_we,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   // Reset is not gated by the enable here; a soft reset is gated by i_ce before it arrives.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_q <= RST;
      else if (i_ce && i_we)
         o_q <= i_d;
   end
endmodule

// ==== design/uxr_sync.sv ====
/*
 Two-flop synchroniser for pin levels.
 Assumes the inputs are slow levels from outside the clock domain.
*/
`timescale 1ns/100ps
module uxr_sync #(
   parameter int W = 2
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ce,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         meta <= '0;
         o_q <= '0;
      end
      else if (i_ce)
      begin
         meta <= i_d;
         o_q <= meta;
      end
   end
endmodule

// ==== verification/uxr_host.sv ====
/*
 Host processor model for the register port of the extended register block.
 Assumes strobes are sampled at the rising edge of i_clk and that read data
 comes back one cycle after the read is taken.
*/
`timescale 1ns/100ps
module uxr_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid,
   output logic o_rd,
   output logic o_wr,
   output logic [2:0] o_addr,
   output logic [7:0] o_wdata
);
   // The bus idles with no strobe before the first request.
   initial
   begin
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_addr = 3'h0;
      o_wdata = 8'h00;
   end

   // One write, held over its sampling edge; released data is inverted
   // so that nothing can lean on a stale value.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
      #1;
   endtask

   // One read; the valid pulse stands for a single cycle after the taking
   // edge, so the answer is sampled just after that edge and not later.
   task automatic rd(input logic [2:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1;
      d = i_rdata;
      v = i_rvalid;
   endtask

   task automatic win_wr(input logic [7:0] off, input logic [7:0] d);
      wr(uxr_pkg::A_SCR, off);
      wr(uxr_pkg::A_WIN, d);
   endtask
endmodule

// ==== verification/test_uxr_top.sv ====
/*
 Self-checking testbench for the extended register access block. Assumes
 the host model drives the register port and the bench drives status.
*/
`timescale 1ns/100ps
module test_uxr_top;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_ce = 1'b1;
   logic i_soft_rst = 1'b0;
   logic i_nine_bit = 1'b0;
   logic rd, wr, rvalid, special;
   logic [2:0] addr;
   logic [7:0] wdata, rdata;
   uxr_pkg::uxr_status_t st;
   uxr_pkg::uxr_cfg_t cfg;
   int err_total = 0;
   int n_checks = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock at 125 MHz; status fields carry distinct values.
   always #4 i_clk = ~i_clk;
   initial
   begin
      st = '0;
      st.tx_idle = 1'b1;
      st.fifo_sel = 1'b1;
      st.int_status = 8'h01;
      st.line_status = 8'h60;
      st.modem_status = 8'h33;
      st.rx_level = 8'h11;
      st.tx_level = 8'h22;
   end

   uxr_host i_host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
      .o_rd(rd), .o_wr(wr), .o_addr(addr), .o_wdata(wdata));

   uxr_top i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
      .i_soft_rst(i_soft_rst), .i_rd(rd), .i_wr(wr), .i_addr(addr),
      .i_wdata(wdata), .i_status(st), .i_dtr_pin(1'b1), .i_rts_pin(1'b0),
      .i_nine_bit(i_nine_bit), .o_rdata(rdata), .o_rvalid(rvalid),
      .o_cfg(cfg), .o_special_mode(special));

   ////////////////////////////////////////////////////////////////////////
   // Compare helpers; values are zero-extended to one width.
   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_host.rd(a, d, v);
      chk("read valid", 16'h0001, {15'h0000, v});
      chk("read data", {8'h00, exp}, {8'h00, d});
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hang is cut well past the hundred or so cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge i_clk);
      err_total++;
      report_and_stop();
   end

   ////////////////////////////////////////////////////////////////////////
   // Test sequence.
   initial
   begin
      repeat (12) @(posedge i_clk);
      i_srst <= 1'b0;
      chk("divisor", 16'h0001, cfg.divisor);
      chk("prescaler", 16'h0020, {8'h00, cfg.clock_prescaler});
      i_host.wr(3'h2, 8'h10);
      chk("features", 16'h0000, {8'h00, cfg.enhanced_features});
      $display("test reset done");

      i_host.win_wr(8'h00, 8'h80);
      i_host.wr(3'h3, 8'h80);
      i_host.wr(3'h0, 8'h34);
      i_host.wr(3'h1, 8'h12);
      chk("divisor", 16'h1234, cfg.divisor);
      rchk(3'h1, 8'h12);
      i_host.wr(3'h3, 8'h03);
      rchk(3'h1, 8'ha8);
      i_host.wr(3'h1, 8'hff);
      chk("tx disable", 16'h0003, {14'h0000, cfg.tx_disable_ctl});
      rchk(3'h1, 8'hab);
      rchk(3'h3, 8'h11);
      rchk(3'h4, 8'h22);
      $display("test status map done");

      i_host.win_wr(8'h00, 8'h00);
      i_host.wr(3'h1, 8'h0f);
      rchk(3'h1, 8'h0f);
      rchk(3'h3, 8'h03);
      i_host.wr(3'h4, 8'h05);
      rchk(3'h4, 8'h05);
      $display("test standard map done");

      i_host.win_wr(8'h00, 8'h40);
      rchk(3'h5, 8'h40);
      i_host.win_wr(8'h05, 8'hff);
      chk("rx trigger", 16'h007f, {9'h000, cfg.rx_irq_trigger});
      rchk(3'h5, 8'h7f);
      i_host.wr(3'h7, 8'h08);
      rchk(3'h5, 8'h5a);
      i_host.win_wr(8'h00, 8'h00);
      rchk(3'h5, 8'h60);
      $display("test window done");

      i_host.wr(3'h3, 8'hbf);
      i_host.wr(3'h2, 8'h10);
      i_host.wr(3'h4, 8'ha1);
      i_host.wr(3'h5, 8'ha2);
      i_host.wr(3'h6, 8'ha3);
      i_host.wr(3'h7, 8'ha4);
      chk("features", 16'h0010, {8'h00, cfg.enhanced_features});
      chk("resume 2", 16'h00a2, {8'h00, cfg.resume_char_2});
      chk("pause 1", 16'h00a3, {8'h00, cfg.pause_char_1});
      chk("rx trigger", 16'h007f, {9'h000, cfg.rx_irq_trigger});
      rchk(3'h4, 8'ha1);
      rchk(3'h7, 8'ha4);
      i_host.wr(3'h3, 8'h03);
      rchk(3'h2, 8'h01);
      i_host.wr(3'h7, 8'h55);
      chk("pause 2", 16'h00a4, {8'h00, cfg.pause_char_2});
      $display("test key mode done");

      @(posedge i_clk);
      i_nine_bit <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk("special mode", 16'h0001, {15'h0000, special});
      @(posedge i_clk);
      i_soft_rst <= 1'b1;
      @(posedge i_clk);
      i_soft_rst <= 1'b0;
      @(posedge i_clk);
      #1;
      chk("divisor", 16'h0001, cfg.divisor);
      chk("rx trigger", 16'h0000, {9'h000, cfg.rx_irq_trigger});
      chk("prescaler", 16'h0020, {8'h00, cfg.clock_prescaler});
      $display("test soft reset done");

      // A write while the clock enable is low must leave no trace.
      @(posedge i_clk);
      i_ce <= 1'b0;
      i_host.wr(3'h7, 8'h66);
      @(posedge i_clk);
      i_ce <= 1'b1;
      rchk(3'h7, 8'h00);
      $display("test clock enable done");
      report_and_stop();
   end
endmodule
